// ---- verilog/acdc_modclk.sv ----
`timescale 1ns/1ns

// divides system clock ticks down to modulator ticks
module acdc_modclk #(
  parameter int unsigned DIV = acdc_pkg::MOD_DIV
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic restart_i,
  input wire logic sys_tick_i,
  output logic mod_tick_o
);
  localparam int unsigned CW = $clog2(DIV);
  // divider count of system ticks
  logic [CW-1:0] cnt;

  // refuse divider values the wrapping counter cannot serve
  if (DIV < 2 || (DIV & (DIV - 1)) != 0)
  begin : g_bad_div
    $error("acdc_modclk: DIV must be a power of two of at least 2");
  end

  // count system ticks, wrap every DIV of them
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt <= '0;
    else if (restart_i)
      cnt <= '0;
    else if (sys_tick_i)
      cnt <= cnt + CW'(1);
  end

  // one pulse, one clock after the last system tick of each group
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mod_tick_o <= 1'b0;
    else
      mod_tick_o <= sys_tick_i && !restart_i && (cnt == CW'(DIV - 1));
  end
endmodule // acdc_modclk

// ---- verilog/acdc_ctrl.sv ----
`timescale 1ns/1ns

// Operation
// R1: separate active-low enable bits per reference buffer
// R2: host disables buffers with internal reference
// R3: host disables buffer when input at rail
// R4: select bit picks internal oscillator or external
// R5: pin or command reset restores internal oscillator
// R6: modulator clock is system clock over sixteen
// R7: oversampling ratio independent of filter type
// R8: codes 0000-0110 map to listed large ratios
// R9: codes 0111-1101 map to listed small ratios
// R10: filter bit zero selects low-latency fir
// R11: low-latency notches follow from ratio length
// R12: rates and notches scale with system clock
// R13: count ticks to ratio, restart on change

// shared constants for the clocking and decimation control
package acdc_pkg;
  // nominal internal oscillator rate in hz
  localparam int unsigned INT_OSC_HZ = 4096000;
  // main clock rate in hz
  localparam int unsigned CLK_HZ = 100000000;
  // phase accumulator width for the oscillator model
  localparam int unsigned NCO_W = 24;
  // oscillator phase step: round(4.096e6 / 100e6 * 2^24)
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(
    (longint'(INT_OSC_HZ) * (longint'(1) << NCO_W) + longint'(CLK_HZ / 2)) / longint'(CLK_HZ));
  // system clock ticks per modulator tick
  localparam int unsigned MOD_DIV = 16;
  // width of the modulator divider count
  localparam int unsigned MOD_DIV_W = 4;
  // rate code width
  localparam int unsigned RATE_W = 4;
  // widest oversampling ratio is 102400, needs 17 bits
  localparam int unsigned OSR_W = 17;
  // filter type encodings
  localparam logic FILT_LOW_LATENCY = 1'b0;
  // clock source encodings
  localparam logic CLK_SRC_INT = 1'b0;
  localparam logic CLK_SRC_EXT = 1'b1;
  // highest defined rate code
  localparam logic [RATE_W-1:0] RATE_MAX = 4'h000d;

  // rate code to oversampling ratio
  function automatic logic [OSR_W-1:0] acdc_osr(input logic [RATE_W-1:0] code);
    logic [OSR_W-1:0] r;
    r = 17'h0_0040;
    unique case (code)
      4'h0000: r = 17'h1_9000; // 102400, 2.5 sps
      4'h0001: r = 17'h0_c800; // 51200, 5 sps
      4'h0002: r = 17'h0_6400; // 25600, 10 sps
      4'h0003: r = 17'h0_3c00; // 15360, 16.6 sps
      4'h0004: r = 17'h0_3200; // 12800, 20 sps
      4'h0005: r = 17'h0_1400; // 5120, 50 sps
      4'h0006: r = 17'h0_10a8; // 4264, 60 sps
      4'h0007: r = 17'h0_0a00; // 2560
      4'h0008: r = 17'h0_0500; // 1280
      4'h0009: r = 17'h0_0280; // 640
      4'h000a: r = 17'h0_0140; // 320
      4'h000b: r = 17'h0_0100; // 256
      4'h000c: r = 17'h0_0080; // 128
      default: r = 17'h0_0040; // 64, also undefined codes
    endcase
    return r;
  endfunction
endpackage

module acdc_ctrl #(
  parameter logic [acdc_pkg::NCO_W-1:0] NCO_STEP = acdc_pkg::NCO_STEP
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // reference buffer control bits, one disables
  input wire logic pos_ref_buffer_disable_i,
  input wire logic neg_ref_buffer_disable_i,
  // clock source write strobe and value
  input wire logic clk_sel_wr_i,
  input wire logic clk_sel_i,
  // reset command pulse
  input wire logic reset_cmd_i,
  // external clock pin, asynchronous
  input wire logic ext_clk_i,
  // configuration
  input wire logic [acdc_pkg::RATE_W-1:0] rate_code_i,
  input wire logic filter_type_i,
  // modulator bitstream, sampled on modulator ticks
  input wire logic mod_bit_i,
  // outputs
  output logic pos_ref_buffer_en_o,
  output logic neg_ref_buffer_en_o,
  output logic clk_src_ext_o,
  output logic sys_tick_o,
  output logic mod_tick_o,
  output logic [acdc_pkg::OSR_W-1:0] osr_o,
  output logic [acdc_pkg::OSR_W-1:0] result_o,
  output logic result_filter_o,
  output logic result_valid_o
);
  localparam int unsigned NW = acdc_pkg::NCO_W;
  localparam int unsigned OW = acdc_pkg::OSR_W;

  // ratio shown while in reset, that of rate code zero
  localparam logic [OW-1:0] OSR_RST = acdc_pkg::acdc_osr('0);

  // a zero step would leave the internal source without ticks
  if (NCO_STEP == '0)
  begin : g_bad_step
    $error("acdc_ctrl: oscillator step must not be zero");
  end

  // buffer enables, held in flops
  logic pos_buf_en;
  logic neg_buf_en;
  // selected clock source
  logic clk_src;
  // external clock synchroniser stages
  logic ext_meta;
  logic ext_sync;
  // previous synchronised level for edge detection
  logic ext_prev;
  // oscillator phase accumulator
  logic [NW:0] nco_acc;
  // system clock tick of the chosen source
  logic sys_tick;
  // configuration seen last cycle
  logic [acdc_pkg::RATE_W-1:0] rate_prev;
  logic filt_prev;
  logic cfg_seen;
  // restart request for divider and decimator
  logic restart;
  // clamped rate code and its ratio
  logic [acdc_pkg::RATE_W-1:0] rate_eff;
  logic [OW-1:0] osr_sel;
  // decimator count and accumulator
  logic [OW-1:0] tick_cnt;
  logic [OW-1:0] acc;
  logic [OW-1:0] next_acc;
  logic last_tick;
  // result registers
  logic [OW-1:0] result;
  logic result_filt;
  logic result_valid;

  // buffer enables are the inverse of the disable bits
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pos_buf_en <= 1'b1;
      neg_buf_en <= 1'b1;
    end
    else
    begin
      pos_buf_en <= !pos_ref_buffer_disable_i; // R1
      neg_buf_en <= !neg_ref_buffer_disable_i; // R1
    end
  end

  // clock source bit; command reset wins over a write
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      clk_src <= acdc_pkg::CLK_SRC_INT; // R5
    else if (reset_cmd_i)
      clk_src <= acdc_pkg::CLK_SRC_INT; // R5
    else if (clk_sel_wr_i)
      clk_src <= clk_sel_i; // R4
  end

  // two-stage synchroniser for the external clock pin
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else
    begin
      ext_meta <= ext_clk_i;
      ext_sync <= ext_meta;
    end
  end

  // edge detector reads only the second stage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ext_prev <= 1'b0;
    else
      ext_prev <= ext_sync;
  end

  // oscillator model: carry out of the accumulator is one tick
  // limitation: ticks jitter by one main clock, average rate set by the rounded step
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      nco_acc <= '0;
    else
      nco_acc <= {1'b0, nco_acc[NW-1:0]} + {1'b0, NCO_STEP};
  end

  // pick the tick source; everything downstream scales with it
  always_comb
  begin
    if (clk_src == acdc_pkg::CLK_SRC_EXT)
      sys_tick = ext_sync && !ext_prev; // R4 R12
    else
      sys_tick = nco_acc[NW]; // R4 R12
  end

  // remember configuration to spot changes
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rate_prev <= '0;
      filt_prev <= acdc_pkg::FILT_LOW_LATENCY;
      cfg_seen <= 1'b0;
    end
    else
    begin
      rate_prev <= rate_code_i;
      filt_prev <= filter_type_i;
      cfg_seen <= 1'b1;
    end
  end

  // restart on any config change, a source switch or reset command
  always_comb
  begin
    restart = reset_cmd_i || (clk_sel_wr_i && clk_sel_i != clk_src)
      || !cfg_seen || rate_code_i != rate_prev || filter_type_i != filt_prev; // R13
  end

  // modulator divider, sixteen system ticks per modulator tick
  acdc_modclk #(
    .DIV(acdc_pkg::MOD_DIV)
  ) u_modclk (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(restart),
    .sys_tick_i(sys_tick),
    .mod_tick_o(mod_tick_o)
  ); // R6

  // undefined codes above the table act as the fastest rate
  always_comb
  begin
    if (rate_code_i > acdc_pkg::RATE_MAX)
      rate_eff = acdc_pkg::RATE_MAX;
    else
      rate_eff = rate_code_i;
    // ratio depends on rate only, never on the filter bit
    osr_sel = acdc_pkg::acdc_osr(rate_eff); // R7 R8 R9
  end

  // last modulator tick of the current conversion
  always_comb
  begin
    last_tick = mod_tick_o && (tick_cnt == osr_sel - OW'(1)); // R13
    // boxcar sum over one ratio; length sets the line notches
    next_acc = acc + OW'(mod_bit_i); // R10 R11
  end

  // count modulator ticks up to the ratio
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tick_cnt <= '0;
    else if (restart)
      tick_cnt <= '0; // R13
    else if (last_tick)
      tick_cnt <= '0; // R13
    else if (mod_tick_o)
      tick_cnt <= tick_cnt + OW'(1); // R13
  end

  // accumulate the bitstream; count of ones fits since osr < 2^17
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      acc <= '0;
    else if (restart)
      acc <= '0; // R13
    else if (last_tick)
      acc <= '0;
    else if (mod_tick_o)
      acc <= next_acc; // R10
  end

  // present one result per completed count
  // fir window is fresh each time, so each result is fully settled
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result <= '0;
      result_filt <= acdc_pkg::FILT_LOW_LATENCY;
      result_valid <= 1'b0;
    end
    else
    begin
      result_valid <= last_tick && !restart; // R13
      if (last_tick && !restart)
      begin
        result <= next_acc; // R10
        result_filt <= filter_type_i;
      end
    end
  end

  // ratio in use, registered for software to read
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      osr_o <= OSR_RST;
    else
      osr_o <= osr_sel; // R8 R9
  end

  // output wiring from the registers above; sys_tick_o comes straight from the tick mux
  assign pos_ref_buffer_en_o = pos_buf_en;
  assign neg_ref_buffer_en_o = neg_buf_en;
  assign clk_src_ext_o = clk_src;
  assign sys_tick_o = sys_tick;
  assign result_o = result;
  assign result_filter_o = result_filt;
  assign result_valid_o = result_valid;
endmodule // acdc_ctrl

// ---- tb/acdc_ctrl_checker.sv ----
`timescale 1ns/1ns

// port-level checker for the clocking and decimation control
module acdc_ctrl_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pos_ref_buffer_disable_i,
  input wire logic neg_ref_buffer_disable_i,
  input wire logic clk_sel_wr_i,
  input wire logic clk_sel_i,
  input wire logic reset_cmd_i,
  input wire logic pos_ref_buffer_en_o,
  input wire logic neg_ref_buffer_en_o,
  input wire logic clk_src_ext_o,
  input wire logic sys_tick_o,
  input wire logic mod_tick_o,
  input wire logic [acdc_pkg::OSR_W-1:0] result_o,
  input wire logic result_valid_o
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_pos_buf_follow: assert property (
    rstn_i |=> pos_ref_buffer_en_o == !$past(pos_ref_buffer_disable_i))
    else $error("positive buffer enable wrong");
  a_neg_buf_follow: assert property (
    rstn_i |=> neg_ref_buffer_en_o == !$past(neg_ref_buffer_disable_i))
    else $error("negative buffer enable wrong");
  a_src_write_taken: assert property (
    clk_sel_wr_i && !reset_cmd_i |=> clk_src_ext_o == $past(clk_sel_i))
    else $error("source write not taken");
  a_cmd_to_internal: assert property (
    reset_cmd_i |=> !clk_src_ext_o)
    else $error("reset command kept external source");
  a_src_holds: assert property (
    !clk_sel_wr_i && !reset_cmd_i |=> $stable(clk_src_ext_o))
    else $error("source changed unasked");
  a_mod_tick_gap: assert property (
    mod_tick_o |=> !mod_tick_o [*8])
    else $error("modulator ticks too close");
  a_mod_from_sys: assert property (
    mod_tick_o |-> $past(sys_tick_o))
    else $error("modulator tick without system tick");
  a_valid_one_cycle: assert property (
    result_valid_o |=> !result_valid_o)
    else $error("valid longer than one cycle");
  a_valid_after_mod: assert property (
    result_valid_o |-> $past(mod_tick_o))
    else $error("result not after modulator tick");
  a_result_stands: assert property (
    !result_valid_o |-> $stable(result_o))
    else $error("result changed without valid");

  // main scenarios
  c_result: cover property (result_valid_o);
  c_ext_write: cover property (clk_sel_wr_i && clk_sel_i && !reset_cmd_i);
  c_cmd_wins: cover property (reset_cmd_i && clk_sel_wr_i);
endmodule // acdc_ctrl_checker

bind acdc_ctrl acdc_ctrl_checker u_checker (.clk_i, .rstn_i, .pos_ref_buffer_disable_i,
  .neg_ref_buffer_disable_i, .clk_sel_wr_i, .clk_sel_i, .reset_cmd_i, .pos_ref_buffer_en_o,
  .neg_ref_buffer_en_o, .clk_src_ext_o, .sys_tick_o, .mod_tick_o, .result_o, .result_valid_o);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns

module tb_top;
  logic clk_i = 0, rstn_i = 0, ext_clk_i = 0;
  logic pos_ref_buffer_disable_i = 0, neg_ref_buffer_disable_i = 0;
  logic clk_sel_wr_i = 0, clk_sel_i = 0, reset_cmd_i = 0, filter_type_i = 0, mod_bit_i = 0;
  logic [acdc_pkg::RATE_W-1:0] rate_code_i = 4'hd;
  logic pos_ref_buffer_en_o, neg_ref_buffer_en_o, clk_src_ext_o, sys_tick_o, mod_tick_o;
  logic result_filter_o, result_valid_o;
  logic [acdc_pkg::OSR_W-1:0] osr_o, result_o;
  int errors = 0, comparisons = 0, cycles = 0;
  // run ceiling, tests need about 35k cycles
  localparam int LIMIT = 60000;

  // faster oscillator step: one system tick every four clocks
  acdc_ctrl #(.NCO_STEP(24'h40_0000)) u_dut (.clk_i, .rstn_i, .pos_ref_buffer_disable_i,
    .neg_ref_buffer_disable_i, .clk_sel_wr_i, .clk_sel_i, .reset_cmd_i, .ext_clk_i, .rate_code_i,
    .filter_type_i, .mod_bit_i, .pos_ref_buffer_en_o, .neg_ref_buffer_en_o, .clk_src_ext_o,
    .sys_tick_o, .mod_tick_o, .osr_o, .result_o, .result_filter_o, .result_valid_o);

  initial forever #5 clk_i = ~clk_i;
  // external pin, phase unrelated to clk_i
  always #31 ext_clk_i = ~ext_clk_i;

  // modulator bit pattern and hang guard
  always @(posedge clk_i)
  begin
    #1;
    cycles++;
    mod_bit_i = (cycles % 3 == 0);
    if (cycles == LIMIT)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      summarize;
    end
  end

  task summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task write_src(input logic cmd, input logic val);
    clk_sel_i = val;
    clk_sel_wr_i = 1'b1;
    reset_cmd_i = cmd;
    step(1);
    clk_sel_wr_i = 1'b0;
    reset_cmd_i = 1'b0;
  endtask

  // system ticks over 600 clocks
  task count_sys(output int n);
    n = 0;
    repeat (600) @(posedge clk_i) n += sys_tick_o;
    #1;
  endtask

  // system ticks between two modulator ticks
  task t_modspan;
    int n;
    n = 0;
    @(posedge clk_i);
    while (mod_tick_o !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    while (mod_tick_o !== 1'b1)
    begin
      n += sys_tick_o;
      @(posedge clk_i);
    end
    check(17'(n), 17'h0_0010);
    #1;
  endtask

  task t_buffers;
    for (int i = 0; i < 4; i++)
    begin
      {neg_ref_buffer_disable_i, pos_ref_buffer_disable_i} = 2'(i);
      step(1);
      check(pos_ref_buffer_en_o, !i[0]);
      check(neg_ref_buffer_en_o, !i[1]);
    end
    // host duty: internal reference in use, both buffers off
    {neg_ref_buffer_disable_i, pos_ref_buffer_disable_i} = 2'h3;
    step(1);
    check({pos_ref_buffer_en_o, neg_ref_buffer_en_o}, 2'h0);
    // host duty: positive input at the upper rail, only that buffer off
    {neg_ref_buffer_disable_i, pos_ref_buffer_disable_i} = 2'h1;
    step(1);
    check({pos_ref_buffer_en_o, neg_ref_buffer_en_o}, 2'h1);
  endtask

  task t_osr;
    logic [16:0] exp [16];
    exp = '{17'h1_9000, 17'h0_c800, 17'h0_6400, 17'h0_3c00, 17'h0_3200, 17'h0_1400, 17'h0_10a8,
      17'h0_0a00, 17'h0_0500, 17'h0_0280, 17'h0_0140, 17'h0_0100, 17'h0_0080, 17'h0_0040,
      17'h0_0040, 17'h0_0040};
    for (int i = 0; i < 16; i++)
    begin
      rate_code_i = 4'(i);
      step(2);
      check(osr_o, exp[i]);
    end
  endtask

  task t_source;
    int n;
    count_sys(n);
    check(n >= 145 && n <= 155, 1'b1);
    write_src(1'b0, 1'b1);
    check(clk_src_ext_o, 1'b1);
    count_sys(n);
    check(n >= 94 && n <= 99, 1'b1);
    t_modspan;
    write_src(1'b1, 1'b1);
    check(clk_src_ext_o, 1'b0);
    // let an edge pass so the strobe is not set twice in one step
    step(1);
    write_src(1'b0, 1'b1);
    rstn_i = 1'b0;
    step(2);
    check(clk_src_ext_o, 1'b0);
    rstn_i = 1'b1;
    step(2);
    t_modspan;
  endtask

  // window from the config change, then one between results
  task t_window(input logic f, input logic [3:0] c, input logic [16:0] n);
    int ticks;
    logic [16:0] ones;
    filter_type_i = f;
    rate_code_i = c;
    @(posedge clk_i);
    for (int k = 0; k < 2; k++)
    begin
      ticks = 0;
      ones = 0;
      @(posedge clk_i);
      while (result_valid_o !== 1'b1)
      begin
        ticks += mod_tick_o;
        if (mod_tick_o === 1'b1) ones += mod_bit_i;
        @(posedge clk_i);
      end
      check(17'(ticks), n);
      check(result_filter_o, f);
      if (k == 1) check(result_o, ones);
    end
    #1;
  endtask

  initial
  begin
    step(11);
    check(pos_ref_buffer_en_o, 1'b1);
    check(clk_src_ext_o, 1'b0);
    check(osr_o, 17'h1_9000);
    step(1);
    rstn_i = 1'b1;
    step(2);
    t_buffers;
    $display("buffers done");
    t_osr;
    $display("ratio table done");
    t_source;
    $display("clock source done");
    t_window(1'b0, 4'hd, 17'h0_0040);
    t_window(1'b1, 4'hd, 17'h0_0040);
    t_window(1'b0, 4'hc, 17'h0_0080);
    $display("decimation done");
    summarize;
  end
endmodule // tb_top
